// >>> asp_defines.vh
`ifndef ASP_DEFINES_VH
`define ASP_DEFINES_VH
// =====================================================================
// register indices (byte address is four times the index)
`define ASP_ADDR_W 16
`define ASP_IDX_CTRL1 16'h001a
`define ASP_IDX_CTRL2 16'h001b
`define ASP_IDX_DIV 16'h001c
`define ASP_IDX_STAT 16'h001d
`define ASP_IDX_BUF 16'h001e
`define ASP_IDX_GATE 16'h0f75
// =====================================================================
// serial_control_one bit positions
`define ASP_C1_TXE 7
`define ASP_C1_RXE 6
`define ASP_C1_STOPT 5
`define ASP_C1_EVEN 4
`define ASP_C1_PAREN 3
`define ASP_C1_IRSEL 2
`define ASP_C1_BASE 1
// serial_control_two fields
`define ASP_C2_RT_HI 5
`define ASP_C2_RT_LO 3
`define ASP_C2_NR_HI 2
`define ASP_C2_NR_LO 1
`define ASP_C2_STOPR 0
// peripheral_clock_gate: channel_clock_gate position
`define ASP_GATE_BIT 0
// =====================================================================
// reset values
`define ASP_RST_BYTE 8'h00
// =====================================================================
// sample clocks per bit
`define ASP_RT_15 5'h0f
`define ASP_RT_16 5'h10
`define ASP_RT_17 5'h11
// noise rejection limits, in divided-clock periods
`define ASP_NR_1 3'h1
`define ASP_NR_2 3'h2
`define ASP_NR_4 3'h4
// infrared pulse length, in sample clocks
`define ASP_IR_PULSE 5'h03
// last data bit index within a frame (start is index 1)
`define ASP_LAST_DATA 4'h9
// axi responses
`define ASP_RESP_OKAY 2'h0
`define ASP_RESP_SLVERR 2'h2
`endif

// >>> asp_rx_filter.v
`timescale 1ns/10ps
`default_nettype none
`include "asp_defines.vh"
// =====================================================================
// receive noise filter: the output follows the input only once the
// input has differed for longer than the selected limit
module asp_rx_filter (
  input wire sys_clk,
  input wire nrst,
  input wire tick,
  input wire [1:0] sel,
  input wire rxd_in,
  output wire rxd_filt
);
  reg filt_q; // filtered level, idles high
  reg [2:0] cnt_q; // ticks the input has disagreed
  reg [2:0] lim; // rejection limit for the code

  // limit decode
  always @*
  begin
    case (sel)
      2'b01: lim = `ASP_NR_1;
      2'b10: lim = `ASP_NR_2;
      default: lim = `ASP_NR_4;
    endcase
  end

  // pulse rejection counter
  always @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      filt_q <= 1'b1;
      cnt_q <= 3'h0;
    end
    else if (sel == 2'b00)
    begin
      // no rejection: one flop of delay only
      filt_q <= rxd_in;
      cnt_q <= 3'h0;
    end
    else if (rxd_in == filt_q)
    begin
      cnt_q <= 3'h0; // pulse ended early: dropped as noise
    end
    else if (tick)
    begin
      if (cnt_q == lim)
      begin
        filt_q <= rxd_in; // longer than the limit: accepted
        cnt_q <= 3'h0;
      end
      else
        cnt_q <= cnt_q + 3'h1;
    end
  end

  assign rxd_filt = filt_q;
endmodule // asp_rx_filter
`default_nettype wire

// >>> asp_top.v
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "asp_defines.vh"
module asp_top (
  input wire sys_clk,
  input wire nrst,
  input wire [15:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [15:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire sys_clk_src,
  input wire slow_clock,
  input wire timer_a_output,
  input wire stop_mode,
  input wire deep_idle_mode,
  input wire deep_sleep_mode,
  input wire port_out_en,
  input wire rxd_in,
  output wire txd_out,
  output wire txd_oe,
  output wire tx_done_irq
);
  // =====================================================================
  // one-hot frame states, shared by both directions
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_START = 5'h02;
  localparam [4:0] ST_DATA = 5'h04;
  localparam [4:0] ST_PAR = 5'h08;
  localparam [4:0] ST_STOP = 5'h10;

  // sample clocks in one frame bit; odd is frame index parity
  function [4:0] bit_len;
    input [2:0] code;
    input odd;
    begin
      case (code)
        3'h0: bit_len = `ASP_RT_16;
        3'h1: bit_len = odd ? `ASP_RT_16 : `ASP_RT_17;
        3'h2: bit_len = `ASP_RT_15;
        3'h3: bit_len = odd ? `ASP_RT_15 : `ASP_RT_16;
        3'h4: bit_len = `ASP_RT_17;
        default: bit_len = `ASP_RT_16; // reserved codes act as 000
      endcase
    end
  endfunction

  // register index match on a byte address
  function hit;
    input [15:0] addr;
    input [15:0] idx;
    begin
      hit = (addr[15:2] == idx[13:0]) && (addr[1:0] == 2'b00);
    end
  endfunction

  // =====================================================================
  // state
  reg awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  reg [1:0] bresp_q, rresp_q;
  reg [31:0] rdata_q;
  reg [15:0] aw_addr_q; // latched write address
  reg [7:0] w_data_q; // latched low byte
  reg w_lane_q; // low byte lane enabled
  reg txe_q, rxe_q, stopt_q, even_q, paren_q, irsel_q, base_q;
  reg [2:0] rtsel_q;
  reg [1:0] nrsel_q;
  reg stopr_q;
  reg [7:0] div_q, gate_q, div_cnt_q;
  reg [4:0] tx_st_q, rx_st_q;
  reg [7:0] tbuf_q, tx_sh_q, rbuf_q, rx_sh_q;
  reg [4:0] tx_rt_q, rx_rt_q; // sample clocks into the bit
  reg [3:0] tx_idx_q, rx_idx_q; // frame bit index, start is 1
  reg tx_line_q, tx_par_q, tx_stop2_q, tbsy_q, tx_full_flag_q, irq_q;
  reg rx_stop2_q, rx_pbad_q, rbsy_q, rx_full_flag_q, parity_error_flag_q, framing_error_flag_q, overrun_error_flag_q;
  reg txd_q, txd_oe_q;
  reg [7:0] rd_byte; // read mux result
  reg rd_ok; // read address is mapped
  reg txd_d, txd_oe_d;

  // =====================================================================
  // combinational terms
  wire low_pwr = stop_mode | deep_idle_mode | deep_sleep_mode;
  wire gate_on = gate_q[`ASP_GATE_BIT];
  wire wr_do = awready_q == 1'b0 && wready_q == 1'b0 && !bvalid_q;
  wire wr_lo = wr_do & w_lane_q;
  wire rd_take = s_axi_arvalid & arready_q;
  wire wr_ok = hit(aw_addr_q, `ASP_IDX_CTRL1) | hit(aw_addr_q, `ASP_IDX_CTRL2) |
    hit(aw_addr_q, `ASP_IDX_DIV) | hit(aw_addr_q, `ASP_IDX_STAT) |
    hit(aw_addr_q, `ASP_IDX_BUF) | hit(aw_addr_q, `ASP_IDX_GATE);
  wire wr_txbuf = wr_lo & hit(aw_addr_q, `ASP_IDX_BUF);
  wire rd_rxbuf = rd_take & hit(s_axi_araddr, `ASP_IDX_BUF);
  wire tx_free = ~txe_q & ~tbsy_q;
  wire rx_free = ~rxe_q & ~rbsy_q;
  wire all_free = tx_free & rx_free;
  // base clock: gear clock is every cycle, slow clock is a pulse
  wire base_tick = gate_on & ~low_pwr & ~base_q & (sys_clk_src ? slow_clock : 1'b1);
  // timer output bypasses the divisor; it is not phase locked to the
  // frame so a start bit may come out short by one tick period
  wire rt_tick = base_q ? (gate_on & ~low_pwr & timer_a_output) :
    (base_tick & (div_cnt_q == div_q));
  wire rxf; // filtered receive level
  wire [4:0] tx_len = bit_len(rtsel_q, tx_idx_q[0]);
  wire [4:0] rx_len = bit_len(rtsel_q, rx_idx_q[0]);
  wire tx_end = rt_tick & (tx_rt_q == tx_len - 5'h01);
  wire rx_end = rt_tick & (rx_rt_q == rx_len - 5'h01);
  wire rx_mid = rt_tick & (rx_rt_q == {1'b0, rx_len[4:1]});
  wire tx_load = tx_st_q == ST_IDLE && txe_q && tx_full_flag_q && rt_tick && !low_pwr;
  wire [7:0] status = {parity_error_flag_q, framing_error_flag_q, overrun_error_flag_q, 1'b0, rbsy_q, rx_full_flag_q, tbsy_q, tx_full_flag_q};

  asp_rx_filter u_filt (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .tick(rt_tick),
    .sel(nrsel_q),
    .rxd_in(rxd_in),
    .rxd_filt(rxf)
  );

  // =====================================================================
  // axi4-lite slave: address and data taken in either order
  always @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= `ASP_RESP_OKAY;
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rresp_q <= `ASP_RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      aw_addr_q <= 16'h0000;
      w_data_q <= `ASP_RST_BYTE;
      w_lane_q <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && awready_q)
      begin
        aw_addr_q <= s_axi_awaddr;
        awready_q <= 1'b0;
      end
      if (s_axi_wvalid && wready_q)
      begin
        w_data_q <= s_axi_wdata[7:0];
        w_lane_q <= s_axi_wstrb[0];
        wready_q <= 1'b0;
      end
      // both halves held: register write happens this cycle
      if (wr_do)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? `ASP_RESP_OKAY : `ASP_RESP_SLVERR;
      end
      if (bvalid_q && s_axi_bready)
      begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
      // reads answer one cycle after the address is taken
      if (rd_take)
      begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q <= {24'h00_0000, rd_byte};
        rresp_q <= rd_ok ? `ASP_RESP_OKAY : `ASP_RESP_SLVERR;
      end
      if (rvalid_q && s_axi_rready)
      begin
        rvalid_q <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  // read mux; the buffer address reads received data
  always @*
  begin
    rd_ok = 1'b1;
    if (hit(s_axi_araddr, `ASP_IDX_CTRL1))
      rd_byte = {txe_q, rxe_q, stopt_q, even_q, paren_q, irsel_q, base_q, 1'b0};
    else if (hit(s_axi_araddr, `ASP_IDX_CTRL2))
      rd_byte = {2'b00, rtsel_q, nrsel_q, stopr_q};
    else if (hit(s_axi_araddr, `ASP_IDX_DIV))
      rd_byte = div_q;
    else if (hit(s_axi_araddr, `ASP_IDX_STAT))
      rd_byte = status;
    else if (hit(s_axi_araddr, `ASP_IDX_BUF))
      rd_byte = rbuf_q; // transmit buffer never reads back
    else if (hit(s_axi_araddr, `ASP_IDX_GATE))
      rd_byte = gate_q;
    else
    begin
      rd_byte = `ASP_RST_BYTE;
      rd_ok = 1'b0;
    end
  end

  // =====================================================================
  // control registers with change protection
  always @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      {txe_q, rxe_q, stopt_q, even_q, paren_q, irsel_q, base_q} <= 7'h00;
      rtsel_q <= 3'h0;
      nrsel_q <= 2'h0;
      stopr_q <= 1'b0;
      div_q <= `ASP_RST_BYTE;
      gate_q <= `ASP_RST_BYTE; // channel off until software sets the gate
    end
    else
    begin
      if (wr_lo && hit(aw_addr_q, `ASP_IDX_CTRL1))
      begin
        txe_q <= w_data_q[`ASP_C1_TXE];
        rxe_q <= w_data_q[`ASP_C1_RXE];
        // protected fields keep old value while enabled or busy
        if (tx_free)
        begin
          stopt_q <= w_data_q[`ASP_C1_STOPT];
          irsel_q <= w_data_q[`ASP_C1_IRSEL];
        end
        if (all_free)
        begin
          even_q <= w_data_q[`ASP_C1_EVEN];
          paren_q <= w_data_q[`ASP_C1_PAREN];
          base_q <= w_data_q[`ASP_C1_BASE];
        end
      end
      if (wr_lo && hit(aw_addr_q, `ASP_IDX_CTRL2))
      begin
        if (all_free)
          rtsel_q <= w_data_q[`ASP_C2_RT_HI:`ASP_C2_RT_LO];
        if (rx_free)
        begin
          nrsel_q <= w_data_q[`ASP_C2_NR_HI:`ASP_C2_NR_LO];
          stopr_q <= w_data_q[`ASP_C2_STOPR];
        end
      end
      // divisor unprotected; software idles the channel first
      if (wr_lo && hit(aw_addr_q, `ASP_IDX_DIV))
        div_q <= w_data_q;
      if (wr_lo && hit(aw_addr_q, `ASP_IDX_GATE))
        gate_q <= w_data_q;
      // low power drops only the enables; the rest is held
      if (low_pwr)
      begin
        txe_q <= 1'b0;
        rxe_q <= 1'b0;
      end
    end
  end

  // baud divisor counter, counts base ticks 0..divisor
  always @(posedge sys_clk)
  begin
    if (!nrst || !gate_on || base_q)
      div_cnt_q <= `ASP_RST_BYTE;
    else if (base_tick)
      div_cnt_q <= (div_cnt_q == div_q) ? `ASP_RST_BYTE : div_cnt_q + 8'h01;
  end

  // =====================================================================
  // transmitter
  always @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      tx_st_q <= ST_IDLE;
      tbuf_q <= `ASP_RST_BYTE;
      tx_sh_q <= `ASP_RST_BYTE;
      tx_rt_q <= 5'h00;
      tx_idx_q <= 4'h0;
      tx_line_q <= 1'b1;
      {tx_par_q, tx_stop2_q, tbsy_q, tx_full_flag_q, irq_q} <= 5'h00;
    end
    else
    begin
      irq_q <= tx_load; // event raised as the byte moves out
      if (wr_txbuf)
        tbuf_q <= w_data_q;
      // write sets, load clears; a disabled channel drops the byte
      tx_full_flag_q <= wr_txbuf | (tx_full_flag_q & ~(tx_load | ~txe_q | low_pwr));
      if (low_pwr)
      begin
        tx_st_q <= ST_IDLE;
        tbsy_q <= 1'b0;
        tx_full_flag_q <= 1'b0;
        tx_line_q <= 1'b1;
        tx_rt_q <= 5'h00;
      end
      else if (tx_load)
      begin
        tx_st_q <= ST_START;
        tx_sh_q <= tbuf_q;
        tx_par_q <= even_q ? ^tbuf_q : ~^tbuf_q;
        tx_line_q <= 1'b0; // start bit low
        tbsy_q <= 1'b1;
        tx_rt_q <= 5'h00;
        tx_idx_q <= 4'h1;
      end
      else if (tx_st_q != ST_IDLE && rt_tick)
      begin
        // frame runs to its end even if the enable drops
        tx_rt_q <= tx_end ? 5'h00 : tx_rt_q + 5'h01;
        if (tx_end)
        begin
          tx_idx_q <= tx_idx_q + 4'h1;
          case (tx_st_q)
            ST_START:
            begin
              tx_st_q <= ST_DATA;
              tx_line_q <= tx_sh_q[0]; // lsb first
            end
            ST_DATA:
            begin
              tx_sh_q <= {1'b0, tx_sh_q[7:1]};
              if (tx_idx_q == `ASP_LAST_DATA)
              begin
                tx_st_q <= paren_q ? ST_PAR : ST_STOP;
                tx_line_q <= paren_q ? tx_par_q : 1'b1;
                tx_stop2_q <= stopt_q;
              end
              else
                tx_line_q <= tx_sh_q[1];
            end
            ST_PAR:
            begin
              tx_st_q <= ST_STOP;
              tx_line_q <= 1'b1;
            end
            ST_STOP:
            begin
              if (tx_stop2_q)
                tx_stop2_q <= 1'b0; // second stop bit
              else
              begin
                tx_st_q <= ST_IDLE;
                tbsy_q <= 1'b0;
              end
            end
            default: tx_st_q <= ST_IDLE;
          endcase
        end
      end
    end
  end

  // pin: plain level or short high pulse per zero bit
  always @*
  begin
    txd_oe_d = 1'b1;
    if (low_pwr)
    begin
      txd_d = ~irsel_q;
      if (stop_mode && !port_out_en)
        txd_oe_d = 1'b0;
    end
    else if (irsel_q)
      txd_d = ~tx_line_q && tx_rt_q < `ASP_IR_PULSE;
    else
      txd_d = tx_line_q;
  end

  always @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      txd_q <= 1'b1;
      txd_oe_q <= 1'b1;
    end
    else
    begin
      txd_q <= txd_d;
      txd_oe_q <= txd_oe_d;
    end
  end

  // =====================================================================
  // receiver, samples at the middle of each bit except the first of two stop bits
  always @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      rx_st_q <= ST_IDLE;
      rbuf_q <= `ASP_RST_BYTE;
      rx_sh_q <= `ASP_RST_BYTE;
      rx_rt_q <= 5'h00;
      rx_idx_q <= 4'h0;
      {rx_stop2_q, rx_pbad_q, rbsy_q, rx_full_flag_q, parity_error_flag_q, framing_error_flag_q, overrun_error_flag_q} <= 7'h00;
    end
    else
    begin
      // reading the buffer frees it and clears the errors; a frame
      // ending in the same cycle sets again below and wins
      if (rd_rxbuf)
      begin
        rx_full_flag_q <= 1'b0;
        {parity_error_flag_q, framing_error_flag_q, overrun_error_flag_q} <= 3'h0;
      end
      if (low_pwr)
      begin
        rx_st_q <= ST_IDLE; // buffer left as is, not guaranteed
        {rbsy_q, rx_full_flag_q, parity_error_flag_q, framing_error_flag_q, overrun_error_flag_q} <= 5'h00;
        rx_rt_q <= 5'h00;
      end
      else if (rx_st_q == ST_IDLE)
      begin
        if (rxe_q && !rxf && rt_tick)
        begin
          rx_st_q <= ST_START;
          rbsy_q <= 1'b1;
          rx_rt_q <= 5'h00;
          rx_idx_q <= 4'h1;
        end
      end
      else if (rt_tick)
      begin
        rx_rt_q <= rx_end ? 5'h00 : rx_rt_q + 5'h01;
        if (rx_end)
          rx_idx_q <= rx_idx_q + 4'h1;
        case (rx_st_q)
          ST_START:
          begin
            if (rx_mid && rxf)
            begin
              rx_st_q <= ST_IDLE; // glitch, not a start bit
              rbsy_q <= 1'b0;
            end
            else if (rx_end)
              rx_st_q <= ST_DATA;
          end
          ST_DATA:
          begin
            if (rx_mid)
              rx_sh_q <= {rxf, rx_sh_q[7:1]}; // lsb first
            if (rx_end && rx_idx_q == `ASP_LAST_DATA)
            begin
              rx_st_q <= paren_q ? ST_PAR : ST_STOP;
              rx_stop2_q <= stopr_q;
              rx_pbad_q <= 1'b0;
            end
          end
          ST_PAR:
          begin
            if (rx_mid)
              rx_pbad_q <= rxf != (even_q ? ^rx_sh_q : ~^rx_sh_q);
            if (rx_end)
              rx_st_q <= ST_STOP;
          end
          ST_STOP:
          begin
            if (rx_stop2_q)
            begin
              if (rx_end)
                rx_stop2_q <= 1'b0; // first of two not checked
            end
            else if (rx_mid)
            begin
              // frame complete at middle of the last stop bit
              rx_st_q <= ST_IDLE;
              rbsy_q <= 1'b0;
              if (rx_full_flag_q && !rd_rxbuf)
                overrun_error_flag_q <= 1'b1; // unread byte kept
              else
              begin
                rbuf_q <= rx_sh_q;
                rx_full_flag_q <= 1'b1;
                parity_error_flag_q <= rx_pbad_q;
                framing_error_flag_q <= ~rxf;
              end
            end
          end
          default: rx_st_q <= ST_IDLE;
        endcase
      end
    end
  end

  // =====================================================================
  // outputs
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign txd_out = txd_q;
  assign txd_oe = txd_oe_q;
  assign tx_done_irq = irq_q;
endmodule // asp_top
`default_nettype wire

// >>> asp_props_properties.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// port checks on the serial port block
module asp_props (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic stop_mode,
  input wire logic deep_idle_mode,
  input wire logic deep_sleep_mode,
  input wire logic port_out_en,
  input wire logic txd_oe,
  input wire logic tx_done_irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // any of the three halting modes
  wire logic low_pwr = stop_mode | deep_idle_mode | deep_sleep_mode;
  // read address accepted this edge
  wire logic ar_take = s_axi_arvalid & s_axi_arready;
  AST_WR_RESP: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write answer late");
  AST_RD_RESP: assert property (ar_take |=> s_axi_rvalid) else $error("read answer late");
  AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data moved");
  AST_HI_ZERO: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  AST_STAT_B4: assert property (ar_take && s_axi_araddr == 16'h0074 |=> !s_axi_rdata[4])
    else $error("status bit 4 set");
  AST_UNMAP: assert property (ar_take && s_axi_araddr == 16'h0000 |=> s_axi_rresp == 2'h2)
    else $error("unmapped read not refused");
  AST_IRQ_PULSE: assert property ($rose(tx_done_irq) |=> !tx_done_irq)
    else $error("irq longer than a cycle");
  AST_LP_QUIET: assert property (low_pwr [*3] |-> !tx_done_irq)
    else $error("irq while halted");
  AST_HIZ: assert property (stop_mode && !port_out_en && !deep_idle_mode && !deep_sleep_mode
    |-> ##[1:2] !txd_oe) else $error("pin still driven");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property ($rose(tx_done_irq));
  cover property (stop_mode && !txd_oe);
endmodule // asp_props
bind asp_top asp_props i_props (.*);
`default_nettype wire

// >>> asp_remote.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// far-end serial device, 16 clocks a bit
module asp_remote (
  input wire logic sys_clk,
  input wire logic txd,
  output logic rxd,
  output logic got,
  output logic [8:0] word
);
  // sender: bit 0 first, line back to idle high after
  task automatic send(input logic [9:0] f);
    for (int i = 0; i < 10; i++)
    begin
      rxd <= f[i];
      repeat (16) @(posedge sys_clk);
    end
    rxd <= 1'b1;
  endtask
  // receiver: eight data bits plus the bit after them
  initial
  begin
    rxd = 1'b1;
    got = 1'b0;
    word = 9'h000;
    forever
    begin
      @(negedge txd);
      repeat (8) @(posedge sys_clk);
      for (int i = 0; i < 9; i++)
      begin
        repeat (16) @(posedge sys_clk);
        word[i] = txd;
      end
      got <= 1'b1;
      @(posedge sys_clk);
      got <= 1'b0;
    end
  end
endmodule // asp_remote
`default_nettype wire

// >>> tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  // ==========================================================
  // stimulus and observed signals
  logic sys_clk = 0, nrst = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, sys_clk_src = 0, slow_clock = 0;
  logic timer_a_output = 0, stop_mode = 0, deep_idle_mode = 0, deep_sleep_mode = 0;
  logic port_out_en = 0;
  logic [15:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 4'h1;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic txd_out, txd_oe, tx_done_irq, got, rxd_in;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic [8:0] word;
  logic [33:0] rq [$];
  logic [8:0] sq [$];
  int bad_count = 0, compares = 0, cyc = 0, irqs = 0;
  logic [7:0] d, cfg;
  logic [15:0] regs [6] = '{16'h0068, 16'h006c, 16'h0070, 16'h0074, 16'h0078, 16'h3dd4};
  logic [7:0] cfgs [3] = '{8'hc0, 8'hc8, 8'hd8};
  asp_top i_dut (.*);
  asp_remote i_rem (.sys_clk(sys_clk), .txd(txd_out), .rxd(rxd_in), .got(got), .word(word));
  initial
  begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  // ==========================================================
  // bus master tasks
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  // expected answer noted before the request goes out
  task automatic rd(input logic [15:0] a, input logic [1:0] r, input logic [7:0] v);
    @(posedge sys_clk);
    rq.push_back({r, 24'h00_0000, v});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask
  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    compares++;
    if (g !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic report_and_stop;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ==========================================================
  // result watcher and hang guard
  always @(posedge sys_clk)
  begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
      chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (got === 1'b1)
      chk({25'h000_0000, word}, {25'h000_0000, sq.pop_front()});
    // one pulse per byte moved out of the buffer
    if (tx_done_irq === 1'b1)
      irqs <= irqs + 1;
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      bad_count++;
      report_and_stop;
    end
  end
  // ==========================================================
  // main sequence
  initial
  begin
    d = 8'($urandom(57186));
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    foreach (regs[i]) rd(regs[i], 2'h0, 8'h00);
    rd(16'h0000, 2'h2, 8'h00);
    wr(16'h3dd4, 8'h01);
    // plain, odd and even parity frames out of the pin
    for (int i = 0; i < 3; i++)
    begin
      cfg = cfgs[i];
      d = 8'($urandom);
      wr(16'h0068, 8'h00);
      wr(16'h0068, cfg);
      sq.push_back({cfg[3] ? ~^{cfg[4], d} : 1'b1, d});
      wr(16'h0078, d);
      while (sq.size() > 0) @(posedge sys_clk);
      repeat (40) @(posedge sys_clk);
    end
    wr(16'h0068, 8'h00);
    wr(16'h0068, 8'hc0);
    // good frame in, then one with a low stop bit
    d = 8'($urandom);
    i_rem.send({1'b1, d, 1'b0});
    repeat (20) @(posedge sys_clk);
    rd(16'h0074, 2'h0, 8'h04);
    rd(16'h0078, 2'h0, d);
    i_rem.send({1'b0, d, 1'b0});
    repeat (20) @(posedge sys_clk);
    rd(16'h0074, 2'h0, 8'h44);
    // protected fields hold while enabled
    wr(16'h0068, 8'hf8);
    rd(16'h0068, 2'h0, 8'hc0);
    // second control and divisor set while idle, then held over low power
    wr(16'h0068, 8'h00);
    wr(16'h006c, 8'hff);
    wr(16'h0070, d);
    wr(16'h0068, 8'he8);
    deep_idle_mode <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk({33'h0_0000_0000, txd_out}, 34'h0_0000_0001);
    deep_idle_mode <= 1'b0;
    rd(16'h0068, 2'h0, 8'h28);
    rd(16'h0074, 2'h0, 8'h00);
    rd(16'h006c, 2'h0, 8'h3f);
    rd(16'h0070, 2'h0, d);
    stop_mode <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk({33'h0_0000_0000, txd_oe}, 34'h0_0000_0000);
    stop_mode <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk(34'(irqs), 34'h0_0000_0003);
    report_and_stop;
  end
endmodule // tb
`default_nettype wire
